// ### rtl/serial_param_select_register.sv
// Write-only serial parameter register on AHB-Lite
// Behaviour
// - Register is write-only, reads return zero; only whole 16-bit or word writes accepted.
// - Every interface takes default parameters at reset; software rewrites as needed.
// - Bits 14-12 pick target: term1, console, printer, comms, panel, term2, term3.
// - Bits 11-08 set the selected interface baud code, 50 through 9600.
// - Bit 07 drives lamp two, bit 06 drives lamp one, zero turns off.
// - Baud code for 110 gives the selected interface two stop bits.
// - Bit 04 enables parity; bit 05 chooses even when 1, odd when 0.
// - Bits 03-02 choose 5, 6, 7 or 8 data bits.
// - Bit 01 sets maintenance loopback for cluster and comms data.
`timescale 1ns/1ps
`default_nettype none
`include "serial_param_consts.svh"
module serial_param_select_register (
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  input  wire logic        clkEn,
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic [3:0]       baudRate [`SP_NUM_PORTS],
  output logic             parityPolarity [`SP_NUM_PORTS],
  output logic             parityCheckOn [`SP_NUM_PORTS],
  output logic [1:0]       wordSizeSelect [`SP_NUM_PORTS],
  output logic             twoStopBits [`SP_NUM_PORTS],
  output logic             panelLampOne,
  output logic             panelLampTwo,
  output logic             diagLoopback
);
  // Port index: 0 term1, 1 console, 2 printer, 3 comms, 4 term2, 5 term3
  serial_param_pkg::bus_state_t state_r;
  serial_param_pkg::bus_state_t state_nxt;
  logic        lamp1_r;
  logic        lamp1_nxt;
  logic        lamp2_r;
  logic        lamp2_nxt;
  logic        loop_r;
  logic        loop_nxt;
  logic [2:0]  sel;
  logic [15:0] wordIn;
  logic        commit;
  logic        addrOk;
  logic [`SP_NUM_PORTS-1:0] load;
  serial_param_pkg::port_cfg_t cfg [`SP_NUM_PORTS];

  // ==========================================
  // AHB-Lite address phase
  always_comb begin
    state_nxt = serial_param_pkg::BUS_IDLE;
    addrOk = (haddr == `SP_PARAM_OFFSET) &&
             ((hsize == `SP_HSIZE_WORD) || (hsize == `SP_HSIZE_HALF));
    if (hsel && hready && htrans[1] && hwrite && addrOk)
      state_nxt = serial_param_pkg::BUS_WRITE;
  end
  always_ff @(posedge core_clk) begin
    if (!reset_n)
      state_r <= serial_param_pkg::BUS_IDLE;
    else if (clkEn)
      state_r <= state_nxt;
  end
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else if (clkEn) begin
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // ==========================================
  // Data phase decode
  assign wordIn = hwdata[15:0];
  assign sel    = wordIn[`SP_SEL_HI:`SP_SEL_LO];
  assign commit = clkEn && (state_r == serial_param_pkg::BUS_WRITE);
  always_comb begin
    load = '0;
    if (commit) begin
      case (sel)
        `SP_SEL_TERM1:   load[0] = 1'b1;
        `SP_SEL_CONSOLE: load[1] = 1'b1;
        `SP_SEL_PRINTER: load[2] = 1'b1;
        `SP_SEL_COMMS:   load[3] = 1'b1;
        `SP_SEL_TERM2:   load[4] = 1'b1;
        `SP_SEL_TERM3:   load[5] = 1'b1;
        default:         load = '0;
      endcase
    end
  end

  // ==========================================
  // Panel lamps and loopback
  always_comb begin
    lamp1_nxt = lamp1_r;
    lamp2_nxt = lamp2_r;
    loop_nxt  = loop_r;
    if (commit) begin
      loop_nxt = wordIn[`SP_LOOP_BIT];
      if (sel == `SP_SEL_PANEL) begin
        lamp1_nxt = wordIn[`SP_LAMP_ONE_BIT];
        lamp2_nxt = wordIn[`SP_LAMP_TWO_BIT];
      end
    end
  end
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      lamp1_r <= 1'b0;
      lamp2_r <= 1'b0;
      loop_r  <= 1'b0;
    end else if (clkEn) begin
      lamp1_r <= lamp1_nxt;
      lamp2_r <= lamp2_nxt;
      loop_r  <= loop_nxt;
    end
  end
  assign panelLampOne = lamp1_r;
  assign panelLampTwo = lamp2_r;
  assign diagLoopback = loop_r;

  // ==========================================
  // Per-interface parameter slots
  genvar gi;
  generate
    for (gi = 0; gi < `SP_NUM_PORTS; gi++) begin : g_slot
      port_cfg_slot u_slot (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .clkEn    (clkEn),
        .load     (load[gi]),
        .wordIn   (wordIn),
        .cfg      (cfg[gi])
      );
      assign baudRate[gi]       = cfg[gi].baud;
      assign parityPolarity[gi] = cfg[gi].parityPolarity;
      assign parityCheckOn[gi]  = cfg[gi].parityCheckOn;
      assign wordSizeSelect[gi] = cfg[gi].wordSizeSelect;
      assign twoStopBits[gi]    = cfg[gi].twoStopBits;
    end
  endgenerate

  // ==========================================
  // Checks
  p_read_zero: assert property (@(posedge core_clk) disable iff (!reset_n)
    hrdata == 32'h0000_0000)
    else $error("Read data not zero");
  p_reset_default: assert property (@(posedge core_clk)
    !reset_n |=> (baudRate[1] == `SP_RESET_BAUD && !panelLampOne))
    else $error("Reset defaults wrong");
  p_console_sel: assert property (@(posedge core_clk) disable iff (!reset_n)
    (commit && sel == `SP_SEL_CONSOLE) |=> baudRate[1] == $past(wordIn[11:8]))
    else $error("Console not loaded");
  p_printer_baud: assert property (@(posedge core_clk) disable iff (!reset_n)
    (commit && sel == `SP_SEL_PRINTER) |=> baudRate[2] == $past(wordIn[11:8]))
    else $error("Printer baud wrong");
  p_lamp: assert property (@(posedge core_clk) disable iff (!reset_n)
    (commit && sel == `SP_SEL_PANEL) |=> panelLampTwo == $past(wordIn[7]))
    else $error("Lamp two wrong");
  p_stop: assert property (@(posedge core_clk) disable iff (!reset_n)
    twoStopBits[3] == (baudRate[3] == `SP_BAUD_110))
    else $error("Stop bits mismatch");
  p_parity: assert property (@(posedge core_clk) disable iff (!reset_n)
    (commit && sel == `SP_SEL_TERM1) |=> parityCheckOn[0] == $past(wordIn[4]) &&
      parityPolarity[0] == $past(wordIn[5]))
    else $error("Parity fields wrong");
  p_wsize: assert property (@(posedge core_clk) disable iff (!reset_n)
    (commit && sel == `SP_SEL_TERM3) |=> wordSizeSelect[5] == $past(wordIn[3:2]))
    else $error("Word size wrong");
  p_loop: assert property (@(posedge core_clk) disable iff (!reset_n)
    commit |=> diagLoopback == $past(wordIn[1]))
    else $error("Loopback wrong");
  p_other: assert property (@(posedge core_clk) disable iff (!reset_n)
    (commit && sel == `SP_SEL_PANEL) |=> $stable(baudRate[4]))
    else $error("Other slot disturbed");
endmodule : serial_param_select_register
`default_nettype wire

// ### rtl/serial_param_consts.svh
// Offsets, field positions, reset values and encodings of the serial parameter register
`ifndef SERIAL_PARAM_CONSTS_SVH
`define SERIAL_PARAM_CONSTS_SVH
`define SP_PARAM_OFFSET     8'h00
`define SP_SEL_HI           14
`define SP_SEL_LO           12
`define SP_BAUD_HI          11
`define SP_BAUD_LO          8
`define SP_LAMP_TWO_BIT     7
`define SP_LAMP_ONE_BIT     6
`define SP_PAR_POL_BIT      5
`define SP_PAR_ON_BIT       4
`define SP_WSZ_HI           3
`define SP_WSZ_LO           2
`define SP_LOOP_BIT         1
`define SP_SEL_TERM1        3'h0
`define SP_SEL_CONSOLE      3'h1
`define SP_SEL_PRINTER      3'h2
`define SP_SEL_COMMS        3'h3
`define SP_SEL_PANEL        3'h4
`define SP_SEL_TERM2        3'h5
`define SP_SEL_TERM3        3'h6
`define SP_BAUD_110         4'h2
`define SP_RESET_BAUD       4'he
`define SP_RESET_WSZ        2'h3
`define SP_NUM_PORTS        6
`define SP_HSIZE_WORD       3'h2
`define SP_HSIZE_HALF       3'h1
`endif

// ### rtl/serial_param_pkg.sv
// Types for the serial parameter register block
package serial_param_pkg;
  typedef struct packed {
    logic [3:0] baud;
    logic       parityPolarity;
    logic       parityCheckOn;
    logic [1:0] wordSizeSelect;
    logic       twoStopBits;
  } port_cfg_t;
  typedef enum logic [1:0] {
    BUS_IDLE  = 2'b01,
    BUS_WRITE = 2'b10
  } bus_state_t;
endpackage : serial_param_pkg

// ### rtl/port_cfg_slot.sv
// One interface's stored parameter set
`timescale 1ns/1ps
`default_nettype none
`include "serial_param_consts.svh"
module port_cfg_slot (
  input  wire logic                       core_clk,
  input  wire logic                       reset_n,
  input  wire logic                       clkEn,
  input  wire logic                       load,
  input  wire logic [15:0]                wordIn,
  output var  serial_param_pkg::port_cfg_t cfg
);
  serial_param_pkg::port_cfg_t cfg_r;
  serial_param_pkg::port_cfg_t cfg_nxt;
  // ==========================================
  // Next value
  always_comb begin
    cfg_nxt = cfg_r;
    if (load) begin
      cfg_nxt.baud           = wordIn[`SP_BAUD_HI:`SP_BAUD_LO];
      cfg_nxt.parityPolarity = wordIn[`SP_PAR_POL_BIT];
      cfg_nxt.parityCheckOn  = wordIn[`SP_PAR_ON_BIT];
      cfg_nxt.wordSizeSelect = wordIn[`SP_WSZ_HI:`SP_WSZ_LO];
      cfg_nxt.twoStopBits    = (wordIn[`SP_BAUD_HI:`SP_BAUD_LO] == `SP_BAUD_110);
    end
  end
  // ==========================================
  // Register
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      cfg_r.baud           <= `SP_RESET_BAUD;
      cfg_r.parityPolarity <= 1'b0;
      cfg_r.parityCheckOn  <= 1'b0;
      cfg_r.wordSizeSelect <= `SP_RESET_WSZ;
      cfg_r.twoStopBits    <= 1'b0;
    end else if (clkEn) begin
      cfg_r <= cfg_nxt;
    end
  end
  assign cfg = cfg_r;
  p_keep: assert property (@(posedge core_clk) disable iff (!reset_n)
    (clkEn && !load) |=> (cfg_r == $past(cfg_r)))
    else $error("Slot changed without a load");
endmodule : port_cfg_slot
`default_nettype wire

// ### tb/serial_param_select_register_bench.sv
// Self-checking bench for the serial parameter register
`timescale 1ns/1ps
`default_nettype none
`include "serial_param_consts.svh"
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin fails++; \
  $display("MISMATCH %s exp=%0h got=%0h", nm, e, g); end end
module serial_param_select_register_bench;
  // ==========================================
  // Signals and design
  logic        core_clk = 0, reset_n = 0, clkEn = 1, hsel = 0, hwrite = 0;
  logic [7:0]  haddr = 0;
  logic [1:0]  htrans = 0;
  logic [2:0]  hsize = 0;
  logic [31:0] hwdata = 0, hrdata;
  logic        hreadyout, hresp, panelLampOne, panelLampTwo, diagLoopback;
  logic [3:0]  baudRate [`SP_NUM_PORTS];
  logic        parityPolarity [`SP_NUM_PORTS], parityCheckOn [`SP_NUM_PORTS], twoStopBits [`SP_NUM_PORTS];
  logic [1:0]  wordSizeSelect [`SP_NUM_PORTS];
  logic [15:0] expW [`SP_NUM_PORTS];
  logic [1:0]  expLamp;
  logic        expLoop;
  int          fails = 0, total_checks = 0;
  serial_param_select_register uut (.core_clk(core_clk), .reset_n(reset_n), .clkEn(clkEn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .baudRate(baudRate), .parityPolarity(parityPolarity),
    .parityCheckOn(parityCheckOn), .wordSizeSelect(wordSizeSelect), .twoStopBits(twoStopBits),
    .panelLampOne(panelLampOne), .panelLampTwo(panelLampTwo), .diagLoopback(diagLoopback));
  initial begin
    forever #25 core_clk = ~core_clk;
  end
  // ==========================================
  // Bus and comparison tasks
  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : finish_test
  task automatic bus(input logic [7:0] a, input logic w, input logic [2:0] s, input logic [31:0] d,
                     output logic [31:0] r);
    int n;
    @(posedge core_clk);
    hsel <= 1; htrans <= 2'h2; haddr <= a; hwrite <= w; hsize <= s;
    n = 0;
    do begin @(posedge core_clk); n++; end while (hreadyout !== 1'b1 && n < 20);
    hsel <= 0; htrans <= 2'h0; hwdata <= d;
    do begin @(posedge core_clk); n++; end while (hreadyout !== 1'b1 && n < 40);
    r = hrdata;
    `CHK("hresp", 1'b0, hresp)
    if (n >= 40) begin fails++; finish_test(); end
  endtask : bus
  task automatic chk_all();
    #1;
    for (int i = 0; i < `SP_NUM_PORTS; i++) begin
      `CHK("baud", expW[i][11:8], baudRate[i])
      `CHK("stop2", (expW[i][11:8] == `SP_BAUD_110), twoStopBits[i])
      `CHK("parPol", expW[i][5], parityPolarity[i])
      `CHK("parOn", expW[i][4], parityCheckOn[i])
      `CHK("wsz", expW[i][3:2], wordSizeSelect[i])
    end
    `CHK("lampTwo", expLamp[1], panelLampTwo)
    `CHK("lampOne", expLamp[0], panelLampOne)
    `CHK("loop", expLoop, diagLoopback)
  endtask : chk_all
  task automatic wr(input logic [2:0] s, input logic [7:0] a, input logic [15:0] w, input logic ok);
    logic [31:0] r;
    int          i;
    bus(a, 1'b1, s, {16'ha5a5, w}, r);
    i = int'(w[14:12]) - ((w[14:12] > 3'h4) ? 1 : 0);
    if (ok && w[14:12] == `SP_SEL_PANEL) expLamp = w[7:6];
    else if (ok && w[14:12] != 3'h7) expW[i] = w;
    if (ok) expLoop = w[1];
    chk_all();
  endtask : wr
  // ==========================================
  // Scenarios
  task automatic t_reset();
    reset_n <= 0;
    repeat (2) @(posedge core_clk);
    reset_n <= 1;
    for (int i = 0; i < `SP_NUM_PORTS; i++) expW[i] = 16'h0e0c;
    expLamp = 2'h0;
    expLoop = 0;
    chk_all();
    $display("Test reset done");
  endtask : t_reset
  task automatic t_select();
    logic [3:0] b;
    for (int s = 0; s < 8; s++) begin
      b = 4'(s + 3);
      wr(s[0] ? `SP_HSIZE_HALF : `SP_HSIZE_WORD, `SP_PARAM_OFFSET,
         {1'b1, s[2:0], b, 2'b11, s[0], s[1], s[1:0], s[2], 1'b1}, 1);
    end
    $display("Test select done");
  endtask : t_select
  task automatic t_baud();
    for (int c = 0; c < 15; c++) begin
      wr(`SP_HSIZE_WORD, `SP_PARAM_OFFSET, {1'b0, `SP_SEL_CONSOLE, 4'(c), 2'b00, c[0], c[1], c[3:2], 2'b00},
         1);
    end
    $display("Test baud done");
  endtask : t_baud
  task automatic t_lamps();
    for (int l = 0; l < 4; l++) begin
      wr(`SP_HSIZE_WORD, `SP_PARAM_OFFSET, {1'b0, `SP_SEL_PANEL, 4'h0, l[1], l[0], 4'h0, l[0], 1'b0}, 1);
    end
    wr(`SP_HSIZE_WORD, `SP_PARAM_OFFSET, 16'h6fc2, 1);
    $display("Test lamps done");
  endtask : t_lamps
  task automatic t_refuse();
    logic [31:0] r;
    bus(`SP_PARAM_OFFSET, 1'b0, `SP_HSIZE_WORD, 32'h0, r);
    `CHK("rdata", 32'h0000_0000, r)
    wr(3'h0, `SP_PARAM_OFFSET, 16'h1532, 0);
    wr(`SP_HSIZE_WORD, 8'h04, 16'h2532, 0);
    clkEn <= 0;
    wr(`SP_HSIZE_WORD, `SP_PARAM_OFFSET, 16'h3532, 0);
    clkEn <= 1;
    $display("Test refuse done");
  endtask : t_refuse
  initial begin
    t_reset();
    t_select();
    t_baud();
    t_lamps();
    t_refuse();
    t_reset();
    finish_test();
  end
endmodule : serial_param_select_register_bench
`default_nettype wire
